// [rtl/prefetch_limits_defs.vh]
// constants for the pre-fetch agent request limits block
`ifndef PREFETCH_LIMITS_DEFS_VH
`define PREFETCH_LIMITS_DEFS_VH
`define PFL_OFFSET        8'he8
`define PFL_RESET         16'h0443
`define PFL_WR_MASK       16'h0fcf
`define PFL_CNT_HI        11
`define PFL_CNT_LO        8
`define PFL_CACHE_HI      7
`define PFL_CACHE_LO      6
`define PFL_LEN_HI        3
`define PFL_LEN_LO        0
`define PFL_CNT_OFF       4'h0
`define PFL_CNT_ONE       4'h1
`define PFL_CACHE_NONE    2'h0
`define PFL_CACHE_LIGHT   2'h1
`define PFL_CACHE_FULL    2'h2
`define PFL_LEN_MAX       4'h7
`define PFL_RESET_CNT     4'h4
`define PFL_RESET_LEN     4'h3
`define PFL_LIMIT_0       14'h0040
`define PFL_LIMIT_1       14'h0080
`define PFL_LIMIT_2       14'h0100
`define PFL_LIMIT_3       14'h0200
`define PFL_LIMIT_4       14'h0400
`define PFL_LIMIT_5       14'h0800
`define PFL_LIMIT_6       14'h1000
`define PFL_LIMIT_7       14'h2000
`endif

// [rtl/limits_register.v]
// configuration register holding the pre-fetch limit fields
`timescale 1ns/10ps
`include "prefetch_limits_defs.vh"
module limits_register (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        globalResetInput,
  input  wire        cfgWrite,
  input  wire [1:0]  cfgByteEn,
  input  wire [15:0] cfgWrData,
  output reg  [15:0] regValue
);
  reg [15:0] nxtValue;
  reg [15:0] laneMask;

  // byte-lane merge, reserved bits forced to zero
  always @* begin
    laneMask = {{8{cfgByteEn[1]}}, {8{cfgByteEn[0]}}} & `PFL_WR_MASK;
    nxtValue = regValue;
    if (cfgWrite) begin
      nxtValue = (regValue & ~laneMask) | (cfgWrData & laneMask);
    end
  end

  // storage, restored on any of the reset sources
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      regValue <= `PFL_RESET;
    end else if (globalResetInput) begin
      regValue <= `PFL_RESET;
    end else begin
      regValue <= nxtValue;
    end
  end
endmodule

// [rtl/prefetch_agent_request_limits.v]
// pre-fetch agent request limit register and burst limiting logic
`timescale 1ns/10ps
`include "prefetch_limits_defs.vh"
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - register bounds data fetched per read thread
// - bits 15:12 read zero, ignore writes
// - reset value is 0443h
// - count zero disables auto prefetch entirely
// - count one: single buffer, no prefetch reads
// - counts 2..F: initial read plus count-1 prefetches when cache mode is 01 or 10; 00 and 11 give no prefetches
// - all reset sources restore the field defaults
// - length code selects 64 B up to 8 KB
// - cache mode selects discard or caching policy
// - bits 5:4 read zero
module prefetch_agent_request_limits (
  input  wire        clk,
  input  wire        rst_n,
  input  wire        globalResetInput,
  input  wire        cfgWrite,
  input  wire        cfgRead,
  input  wire [7:0]  cfgAddr,
  input  wire [1:0]  cfgByteEn,
  input  wire [15:0] cfgWrData,
  output reg  [15:0] cfgRdData,
  output reg         cfgRdValid,
  input  wire        threadStart,
  input  wire        readIssued,
  input  wire        threadEnd,
  input  wire        dataReturned,
  input  wire        masterTerminated,
  input  wire        bridgeRetry,
  output reg         threadActive,
  output reg         prefetchReq,
  output reg  [13:0] threadByteLimit,
  output reg         discardLeftover,
  output reg         cacheLeftover
);
  localparam ST_IDLE = 2'h1;
  localparam ST_RUN  = 2'h2;

  wire [15:0] regValue;
  reg  [1:0]  state_ff;
  reg  [1:0]  nxt_state;
  reg  [3:0]  prefetch_burst_read_count;
  reg  [1:0]  completion_cache_policy;
  reg  [3:0]  prefetch_thread_byte_length;
  reg  [3:0]  issued_ff;
  reg  [3:0]  nxt_issued;
  wire        hit;
  reg         prefetchAllowed;
  reg         budgetLeft;
  reg         nxt_prefetchReq;
  reg  [13:0] nxt_byteLimit;
  reg         nxt_discard;
  reg         nxt_cache;

  //////////////////////////////////////////////////////////////////////////////
  // register storage
  limits_register limits_register_i (
    .clk              (clk),
    .rst_n            (rst_n),
    .globalResetInput (globalResetInput),
    .cfgWrite         (cfgWrite & (cfgAddr == `PFL_OFFSET)),
    .cfgByteEn        (cfgByteEn),
    .cfgWrData        (cfgWrData),
    .regValue         (regValue)
  );

  // read port, unmapped offsets answer zero
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgRdData  <= 16'h0000;
      cfgRdValid <= 1'b0;
    end else begin
      cfgRdValid <= cfgRead;
      cfgRdData  <= (cfgRead && cfgAddr == `PFL_OFFSET) ? regValue : 16'h0000;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // thread sequencer
  always @* begin
    nxt_state  = state_ff;
    nxt_issued = issued_ff;
    case (state_ff)
      ST_IDLE: begin
        nxt_issued = 4'h0;
        if (threadStart) begin
          nxt_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (threadEnd) begin
          nxt_state = ST_IDLE;
        end else if (readIssued && prefetchReq) begin
          nxt_issued = issued_ff + 4'h1;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // limits captured once per thread
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff                    <= ST_IDLE;
      issued_ff                   <= 4'h0;
      prefetch_burst_read_count   <= `PFL_RESET_CNT;
      completion_cache_policy     <= `PFL_CACHE_LIGHT;
      prefetch_thread_byte_length <= `PFL_RESET_LEN;
    end else begin
      state_ff  <= nxt_state;
      issued_ff <= nxt_issued;
      if (state_ff == ST_IDLE && threadStart) begin
        prefetch_burst_read_count   <= regValue[`PFL_CNT_HI:`PFL_CNT_LO];
        completion_cache_policy     <= regValue[`PFL_CACHE_HI:`PFL_CACHE_LO];
        prefetch_thread_byte_length <= regValue[`PFL_LEN_HI:`PFL_LEN_LO];
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // outputs to the read engine

  // prefetch only under the two caching codes; 00 and reserved 11 stop it
  always @* begin
    prefetchAllowed = 1'b0;
    case (completion_cache_policy)
      `PFL_CACHE_LIGHT: prefetchAllowed = 1'b1;
      `PFL_CACHE_FULL:  prefetchAllowed = 1'b1;
      default:          prefetchAllowed = 1'b0;
    endcase
  end

  // count 0 and 1 never prefetch, else up to count-1 after the first read
  always @* begin
    budgetLeft = 1'b0;
    case (prefetch_burst_read_count)
      `PFL_CNT_OFF: budgetLeft = 1'b0;
      `PFL_CNT_ONE: budgetLeft = 1'b0;
      default:      budgetLeft = (nxt_issued < prefetch_burst_read_count - 4'h1);
    endcase
  end

  // grant only once the thread has been running for a cycle
  always @* begin
    nxt_prefetchReq = 1'b0;
    if (state_ff == ST_RUN && nxt_state == ST_RUN) begin
      nxt_prefetchReq = budgetLeft && prefetchAllowed;
    end
  end

  // thread state and prefetch grant
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      threadActive <= 1'b0;
      prefetchReq  <= 1'b0;
    end else begin
      threadActive <= (nxt_state == ST_RUN);
      prefetchReq  <= nxt_prefetchReq;
    end
  end

  // bytes per thread from the length code; reserved codes give zero
  always @* begin
    nxt_byteLimit = 14'h0000;
    case (prefetch_thread_byte_length)
      4'h0:    nxt_byteLimit = `PFL_LIMIT_0;
      4'h1:    nxt_byteLimit = `PFL_LIMIT_1;
      4'h2:    nxt_byteLimit = `PFL_LIMIT_2;
      4'h3:    nxt_byteLimit = `PFL_LIMIT_3;
      4'h4:    nxt_byteLimit = `PFL_LIMIT_4;
      4'h5:    nxt_byteLimit = `PFL_LIMIT_5;
      4'h6:    nxt_byteLimit = `PFL_LIMIT_6;
      4'h7:    nxt_byteLimit = `PFL_LIMIT_7;
      default: nxt_byteLimit = 14'h0000;
    endcase
  end

  // byte limit register
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      threadByteLimit <= 14'h0000;
    end else begin
      threadByteLimit <= nxt_byteLimit;
    end
  end

  // data return seen while a thread runs
  assign hit = dataReturned && (state_ff == ST_RUN);

  // leftover completion data policy; a retry wins over a master end
  always @* begin
    nxt_discard = hit;
    nxt_cache   = 1'b0;
    case (completion_cache_policy)
      `PFL_CACHE_NONE: begin
        nxt_discard = hit;
        nxt_cache   = 1'b0;
      end
      `PFL_CACHE_LIGHT: begin
        nxt_discard = hit && masterTerminated && !bridgeRetry;
        nxt_cache   = hit && bridgeRetry;
      end
      `PFL_CACHE_FULL: begin
        nxt_discard = 1'b0;
        nxt_cache   = hit && (masterTerminated || bridgeRetry);
      end
      default: begin
        nxt_discard = hit;
        nxt_cache   = 1'b0;
      end
    endcase
  end

  // leftover strobes, one cycle after the data return
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      discardLeftover <= 1'b0;
      cacheLeftover   <= 1'b0;
    end else begin
      discardLeftover <= nxt_discard;
      cacheLeftover   <= nxt_cache;
    end
  end
endmodule

// [dv/prefetch_limits_sva.sv]
// port assertions for the prefetch limit block
`timescale 1ns/10ps
module prefetch_limits_sva (
  input wire        clk,
  input wire        rst_n,
  input wire        globalResetInput,
  input wire        cfgWrite,
  input wire        cfgRead,
  input wire [7:0]  cfgAddr,
  input wire        threadStart,
  input wire        threadEnd,
  input wire        dataReturned,
  input wire        bridgeRetry,
  input wire        masterTerminated,
  input wire [15:0] cfgRdData,
  input wire        cfgRdValid,
  input wire        threadActive,
  input wire        prefetchReq,
  input wire        cacheLeftover,
  input wire        discardLeftover
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_read_answer: assert property (cfgRead |=> cfgRdValid)
    else $error("read not answered");
  chk_high_zero: assert property (cfgRdValid |-> cfgRdData[15:12] == 4'h0)
    else $error("bits 15:12 not zero");
  chk_mid_zero: assert property (cfgRdValid |-> cfgRdData[5:4] == 2'h0)
    else $error("bits 5:4 not zero");
  chk_glob_default: assert property (globalResetInput ##1 !cfgWrite ##1 (cfgRead
    && !cfgWrite && cfgAddr == 8'he8) |=> cfgRdData == 16'h0443) else $error("no default");
  chk_other_addr: assert property (cfgRead && cfgAddr != 8'he8 |=> cfgRdData == 16'h0)
    else $error("unmapped read not zero");
  chk_start_quiet: assert property (threadStart && !threadActive
    |=> threadActive && !prefetchReq) else $error("bad thread start");
  chk_end_stops: assert property (threadEnd |=> !threadActive && !prefetchReq)
    else $error("thread did not stop");
  chk_cache_cause: assert property (cacheLeftover
    |-> $past(dataReturned & (bridgeRetry | masterTerminated))) else $error("bad cache");
  chk_one_policy: assert property (!(cacheLeftover && discardLeftover))
    else $error("cache and discard together");
  chk_discard_cause: assert property (discardLeftover |-> $past(dataReturned))
    else $error("discard without data return");
endmodule

// [dv/prefetch_engine_model.sv]
// far-side engine issuing prefetch reads while allowed
`timescale 1ns/10ps
module prefetch_engine_model (
  input  wire       clk,
  input  wire       rst_n,
  input  wire       prefetchReq,
  output reg        readIssued,
  output reg  [7:0] issuedCount
);
  // one read per two cycles so a lagging grant is never overrun
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      readIssued <= 1'b0;
      issuedCount <= 8'h00;
    end else begin
      readIssued <= prefetchReq & ~readIssued;
      issuedCount <= issuedCount + {7'h00, readIssued};
    end
  end
endmodule

// [dv/tb_prefetch_agent_request_limits.sv]
// self-checking bench for the prefetch limit block
`timescale 1ns/10ps
`include "prefetch_limits_defs.vh"
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %s exp %h got %h", n, e, g); end end
module tb_prefetch_agent_request_limits;
  reg clk = 0, rst_n = 0, globalResetInput = 0, cfgWrite = 0, cfgRead = 0;
  reg threadStart = 0, threadEnd = 0, dataReturned = 0;
  reg bridgeRetry = 1, masterTerminated = 0;
  reg [7:0] cfgAddr = 8'he8;
  reg [1:0] cfgByteEn = 2'h3;
  reg [15:0] cfgWrData = 16'h0;
  wire [15:0] cfgRdData;
  wire [13:0] threadByteLimit;
  wire [7:0] issuedCount;
  wire cfgRdValid, threadActive, prefetchReq, discardLeftover, cacheLeftover, readIssued;
  integer err_count = 0, compares = 0;
  prefetch_agent_request_limits prefetch_agent_request_limits_i (
    .clk(clk), .rst_n(rst_n), .globalResetInput(globalResetInput),
    .cfgWrite(cfgWrite), .cfgRead(cfgRead), .cfgAddr(cfgAddr), .cfgByteEn(cfgByteEn),
    .cfgWrData(cfgWrData), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
    .threadStart(threadStart), .readIssued(readIssued), .threadEnd(threadEnd),
    .dataReturned(dataReturned), .masterTerminated(masterTerminated),
    .bridgeRetry(bridgeRetry), .threadActive(threadActive), .prefetchReq(prefetchReq),
    .threadByteLimit(threadByteLimit), .discardLeftover(discardLeftover),
    .cacheLeftover(cacheLeftover));
  prefetch_engine_model prefetch_engine_model_i (
    .clk(clk), .rst_n(rst_n), .prefetchReq(prefetchReq), .readIssued(readIssued),
    .issuedCount(issuedCount));
  always #20 clk = ~clk;
  task cfg_wr(input [1:0] be, input [15:0] d);
    begin
      @(posedge clk) cfgAddr <= `PFL_OFFSET;
      cfgByteEn <= be;
      cfgWrData <= d;
      cfgWrite <= 1'b1;
      @(posedge clk) cfgWrite <= 1'b0;
    end
  endtask
  task cfg_rd(input [7:0] a, input [15:0] e);
    begin
      @(posedge clk) cfgAddr <= a;
      cfgRead <= 1'b1;
      @(posedge clk) cfgRead <= 1'b0;
      #1 `CHK("rdData", e, cfgRdData)
      `CHK("rdValid", 1'b1, cfgRdValid)
    end
  endtask
  // one thread: reads allowed, byte limit, leftover policy, end
  task run_thread(input [15:0] v, input [7:0] n, input [13:0] len);
    reg [7:0] base;
    begin
      cfg_wr(2'h3, v);
      base = issuedCount;
      @(posedge clk) threadStart <= 1'b1;
      @(posedge clk) threadStart <= 1'b0;
      cfg_wr(2'h3, 16'h0000); // change mid-thread
      repeat (40) @(posedge clk);
      `CHK("reads", n, issuedCount - base)
      `CHK("len", len, threadByteLimit)
      `CHK("req", 1'b0, prefetchReq)
      `CHK("busy", 1'b1, threadActive)
      @(posedge clk) dataReturned <= 1'b1;
      @(posedge clk) dataReturned <= 1'b0;
      #1 `CHK("cache", v[7:6] == 2'h1 || v[7:6] == 2'h2, cacheLeftover)
      `CHK("discard", v[7:6] == 2'h0 || v[7:6] == 2'h3, discardLeftover)
      @(posedge clk) dataReturned <= 1'b1;
      masterTerminated <= 1'b1;
      bridgeRetry <= 1'b0;
      @(posedge clk) dataReturned <= 1'b0;
      masterTerminated <= 1'b0;
      bridgeRetry <= 1'b1;
      #1 `CHK("mtCache", v[7:6] == 2'h2, cacheLeftover)
      `CHK("mtDiscard", v[7:6] != 2'h2, discardLeftover)
      @(posedge clk) threadEnd <= 1'b1;
      @(posedge clk) threadEnd <= 1'b0;
      #1 `CHK("active", 1'b0, threadActive)
    end
  endtask
  // both reset sources bring the register back to its default
  task check_resets;
    begin
      @(posedge clk) globalResetInput <= 1'b1;
      @(posedge clk) globalResetInput <= 1'b0;
      cfg_rd(`PFL_OFFSET, `PFL_RESET);
      cfg_wr(2'h3, 16'h0000);
      @(posedge clk) rst_n <= 1'b0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      #1 `CHK("rstValid", 1'b0, cfgRdValid)
      cfg_rd(`PFL_OFFSET, `PFL_RESET);
    end
  endtask
  task give_verdict;
    begin
      if (err_count == 0 && compares > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    cfg_rd(`PFL_OFFSET, `PFL_RESET);
    cfg_rd(8'he4, 16'h0000);
    cfg_wr(2'h3, 16'hffff);
    cfg_rd(`PFL_OFFSET, 16'h0fcf);
    cfg_wr(2'h1, 16'h0000);
    cfg_rd(`PFL_OFFSET, 16'h0f00);
    check_resets;
    run_thread(16'h0341, 8'h02, 14'h0080);
    run_thread(16'h0041, 8'h00, 14'h0080);
    run_thread(16'h0141, 8'h00, 14'h0080);
    run_thread(16'h0303, 8'h00, 14'h0200);
    run_thread(16'h0f87, 8'h0e, 14'h2000);
    run_thread(16'h0248, 8'h01, 14'h0000);
    run_thread(16'h03c2, 8'h00, 14'h0100);
    give_verdict;
  end
endmodule
bind prefetch_agent_request_limits prefetch_limits_sva prefetch_limits_sva_i (
  .clk(clk), .rst_n(rst_n), .globalResetInput(globalResetInput), .cfgWrite(cfgWrite),
  .cfgRead(cfgRead), .cfgAddr(cfgAddr), .threadStart(threadStart), .threadEnd(threadEnd),
  .dataReturned(dataReturned), .bridgeRetry(bridgeRetry),
  .masterTerminated(masterTerminated), .cfgRdData(cfgRdData), .cfgRdValid(cfgRdValid),
  .threadActive(threadActive), .prefetchReq(prefetchReq), .cacheLeftover(cacheLeftover),
  .discardLeftover(discardLeftover));
